// [shared/inhibit_pkg.sv]
package inhibit_pkg;
	localparam int CLK_HZ = 50_000_000;
	// one-second tick divider
	localparam int TICK_CYCLES = CLK_HZ;
	localparam int FORCED_OFF_DELAY_S = 2;
	localparam int COMM_HOLD_S = 30;
	localparam logic [7:0] CMD_ON_A = 8'h1f;
	localparam logic [7:0] CMD_ON_B = 8'h20;
	localparam logic [7:0] CMD_OFF = 8'h21;
	localparam int EVT_ENABLE_BIT = 6;
	localparam int SEC_PER_DAY = 86400;
	// start sources: input, scheduler, load mgmt, mains, breaker fault, mains ctrl
	localparam int START_SRC_N = 6;
	// closure sources: input, mains, comm port, breaker fault, mains-breaker sync, mains ctrl
	localparam int CLOSE_SRC_N = 6;

	typedef struct packed {
		logic [START_SRC_N-1:0] start_src;
		logic [CLOSE_SRC_N-1:0] close_src;
	} inhibit_status_t;

	typedef struct packed {
		logic valid;
		logic [7:0] code;
	} remote_cmd_t;
endpackage

// [logic/genset_start_and_breaker_inhibit.sv]
`timescale 1ns/1ns
`default_nettype none
module genset_start_and_breaker_inhibit #(
	parameter int IN_N = 4,
	parameter int MC_N = 4,
	parameter int DELAY_W = 16,
	parameter int TICK_CYCLES = inhibit_pkg::TICK_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [IN_N-1:0] din_i,
	input wire logic [IN_N-1:0] start_block_input_function_i,
	input wire logic [IN_N-1:0] supply_block_input_function_i,
	input wire logic [DELAY_W-1:0] on_delay_s_i,
	input wire logic [DELAY_W-1:0] off_delay_s_i,
	input wire logic [DELAY_W-1:0] max_mains_fail_s_i,
	input wire logic auto_mode_i,
	input wire logic auto_submode_i,
	input wire logic gen_running_i,
	input wire logic [6:0] enable_days_i,
	input wire logic [2:0] weekday_i,
	input wire logic [16:0] start_time_s_i,
	input wire logic [16:0] stop_time_s_i,
	input wire logic [16:0] now_s_i,
	input wire logic clock_reliable_i,
	input wire logic load_mgmt_stop_i,
	input wire logic parallel_to_mains_app_i,
	input wire logic automatic_mains_failure_app_i,
	input wire logic mains_suitable_i,
	input wire logic breaker_fault_i,
	input wire logic [MC_N-1:0] mc_connected_i,
	input wire logic [MC_N-1:0] mc_inhibit_i,
	input wire logic mc_open_request_i,
	input wire logic sync_in_progress_i,
	input wire logic generator_breaker_closed_i,
	input wire logic unload_allowed_i,
	input wire logic generator_unloaded_i,
	input wire inhibit_pkg::remote_cmd_t remote_cmd_i,
	input wire logic [7:0] event_mask_i,
	output logic start_inhibit_o,
	output logic close_inhibit_o,
	output logic unload_request_o,
	output logic open_generator_breaker_o,
	output logic clock_invalid_anomaly_o,
	output inhibit_pkg::inhibit_status_t status_o,
	output logic [inhibit_pkg::START_SRC_N-1:0] start_evt_on_o,
	output logic [inhibit_pkg::START_SRC_N-1:0] start_evt_off_o,
	output logic [inhibit_pkg::CLOSE_SRC_N-1:0] close_evt_on_o,
	output logic close_evt_all_off_o
);
	// pin inputs pass two flops; everything else is same-clock logic
	logic [IN_N-1:0] din_meta;
	logic [IN_N-1:0] din_sync;
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			din_meta <= '0;
			din_sync <= '0;
		end else begin
			din_meta <= din_i;
			din_sync <= din_meta;
		end
	end

	logic [31:0] tick_cnt;
	logic tick;
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
			tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 32'h0000_0001;
		end
	end

	// digital input start request with on/off delays
	logic din_start_raw;
	logic din_start;
	logic [DELAY_W-1:0] din_cnt;
	logic [DELAY_W-1:0] on_lim;
	logic [DELAY_W-1:0] off_lim;
	assign din_start_raw = |(din_sync & start_block_input_function_i);
	assign on_lim = auto_mode_i ? on_delay_s_i : '0;
	assign off_lim = gen_running_i ? DELAY_W'(inhibit_pkg::FORCED_OFF_DELAY_S) : off_delay_s_i;
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			din_start <= 1'b0;
			din_cnt <= '0;
		end else if (din_start_raw == din_start) begin
			din_cnt <= '0;
		end else if ((din_start_raw ? on_lim : off_lim) <= din_cnt) begin
			din_start <= din_start_raw;
			din_cnt <= '0;
		end else if (tick) begin
			din_cnt <= din_cnt + DELAY_W'(1);
		end
	end

	// scheduler window; wraps midnight when stop precedes start
	function automatic logic in_window(input logic [16:0] t, input logic [16:0] a,
		input logic [16:0] b);
		if (a == b)
			return 1'b1;
		else if (a < b)
			return (t >= a) && (t < b);
		else
			return (t >= a) || (t < b);
	endfunction
	logic [2:0] prev_day;
	logic after_mid;
	logic sched_allow;
	assign prev_day = (weekday_i == 3'h0) ? 3'h6 : weekday_i - 3'h1;
	assign after_mid = (stop_time_s_i < start_time_s_i) && (now_s_i < stop_time_s_i);
	// early-morning tail belongs to the previous day's enable bit
	assign sched_allow = in_window(now_s_i, start_time_s_i, stop_time_s_i) &&
		(after_mid ? enable_days_i[prev_day] : enable_days_i[weekday_i]);
	assign clock_invalid_anomaly_o = !clock_reliable_i;

	// mains and breaker-fault timeouts share the max mains failure time
	logic [DELAY_W-1:0] mains_cnt;
	logic [DELAY_W-1:0] fault_cnt;
	logic mains_start;
	logic fault_start;
	logic mains_bad;
	assign mains_bad = parallel_to_mains_app_i && !mains_suitable_i;
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			mains_cnt <= '0;
			mains_start <= 1'b0;
		end else if (!mains_bad) begin
			mains_cnt <= '0;
			mains_start <= 1'b0;
		end else if (mains_cnt >= max_mains_fail_s_i) begin
			mains_start <= 1'b1;
		end else if (tick) begin
			mains_cnt <= mains_cnt + DELAY_W'(1);
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			fault_cnt <= '0;
			fault_start <= 1'b0;
		end else if (!breaker_fault_i) begin
			fault_cnt <= '0;
			fault_start <= 1'b0;
		end else if (fault_cnt >= max_mains_fail_s_i) begin
			fault_start <= 1'b1;
		end else if (tick) begin
			fault_cnt <= fault_cnt + DELAY_W'(1);
		end
	end

	logic mc_all;
	// no connected mains controller means no consensus
	assign mc_all = (|mc_connected_i) && ((mc_connected_i & mc_inhibit_i) == mc_connected_i);

	// comm port closure request with 30 s lifetime
	logic comm_req;
	logic [7:0] comm_cnt;
	logic cmd_ok;
	logic amf_fail;
	assign amf_fail = automatic_mains_failure_app_i && !mains_suitable_i;
	assign cmd_ok = remote_cmd_i.valid && !amf_fail;
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			comm_req <= 1'b0;
			comm_cnt <= '0;
		end else if (cmd_ok && (remote_cmd_i.code == inhibit_pkg::CMD_ON_A ||
			remote_cmd_i.code == inhibit_pkg::CMD_ON_B)) begin
			comm_req <= 1'b1;
			comm_cnt <= '0;
		end else if (cmd_ok && remote_cmd_i.code == inhibit_pkg::CMD_OFF) begin
			comm_req <= 1'b0;
			comm_cnt <= '0;
		end else if (comm_req && comm_cnt >= 8'(inhibit_pkg::COMM_HOLD_S)) begin
			comm_req <= 1'b0;
		end else if (comm_req && tick) begin
			comm_cnt <= comm_cnt + 8'h01;
		end
	end

	logic [inhibit_pkg::START_SRC_N-1:0] start_src;
	logic [inhibit_pkg::CLOSE_SRC_N-1:0] close_src;
	always_comb begin
		start_src = {mc_all, fault_start, mains_start, load_mgmt_stop_i, !sched_allow,
			din_start};
		close_src = {mc_open_request_i,
			sync_in_progress_i && !generator_breaker_closed_i,
			breaker_fault_i,
			comm_req,
			mains_bad,
			|(din_sync & supply_block_input_function_i)};
	end

	logic [inhibit_pkg::START_SRC_N-1:0] start_prev;
	logic [inhibit_pkg::CLOSE_SRC_N-1:0] close_prev;
	logic evt_en;
	assign evt_en = event_mask_i[inhibit_pkg::EVT_ENABLE_BIT];
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			start_prev <= '0;
			close_prev <= '0;
			start_evt_on_o <= '0;
			start_evt_off_o <= '0;
			close_evt_on_o <= '0;
			close_evt_all_off_o <= 1'b0;
			status_o <= '0;
			start_inhibit_o <= 1'b0;
			close_inhibit_o <= 1'b0;
			unload_request_o <= 1'b0;
			open_generator_breaker_o <= 1'b0;
		end else begin
			start_prev <= start_src;
			close_prev <= close_src;
			// load management and mains-controller start sources log no events
			start_evt_on_o <= evt_en ? (start_src & ~start_prev & 6'b01_1011) : '0;
			start_evt_off_o <= evt_en ? (~start_src & start_prev & 6'b01_1011) : '0;
			close_evt_on_o <= evt_en ? (close_src & ~close_prev) : '0;
			close_evt_all_off_o <= evt_en && (close_src == '0) && (close_prev != '0);
			status_o <= '{start_src: start_src, close_src: close_src};
			start_inhibit_o <= auto_mode_i && !auto_submode_i && (|start_src);
			close_inhibit_o <= |close_src;
			unload_request_o <= (|close_src) && unload_allowed_i &&
				generator_breaker_closed_i && !mains_bad;
			// mains anomaly opens at once; others wait for unload only when unload is allowed
			open_generator_breaker_o <= mains_bad || ((|close_src) &&
				(!unload_allowed_i || generator_unloaded_i));
		end
	end

	a_close_or: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		close_inhibit_o == $past(|close_src)) else $error("closure inhibit not OR");
	a_start_auto: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		start_inhibit_o |-> $past(auto_mode_i && !auto_submode_i)) else $error("start out of auto");
	a_comm_on: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(remote_cmd_i.valid && !amf_fail && remote_cmd_i.code == inhibit_pkg::CMD_ON_A)
		|=> comm_req) else $error("comm on lost");
	a_comm_reject: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(amf_fail && !comm_req) |=> !comm_req) else $error("comm taken in mains fail");
	a_comm_off: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(cmd_ok && remote_cmd_i.code == inhibit_pkg::CMD_OFF) |=> !comm_req) else $error("comm off");
	a_mc_any: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		((mc_connected_i & ~mc_inhibit_i) != '0) |=> !status_o.start_src[5]) else $error("mc consensus");
	a_mains_open: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		mains_bad |=> open_generator_breaker_o && close_inhibit_o) else $error("mains open");
	a_sync_close: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(sync_in_progress_i && !generator_breaker_closed_i) |=> close_inhibit_o)
		else $error("sync inhibit");
	a_all_off: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		close_evt_all_off_o |-> !close_inhibit_o) else $error("all-off event with active source");

	// activating command accepted this cycle
	logic comm_arm;
	logic [31:0] comm_age;
	assign comm_arm = cmd_ok && (remote_cmd_i.code == inhibit_pkg::CMD_ON_A ||
		remote_cmd_i.code == inhibit_pkg::CMD_ON_B);
	// cycle count, since 30 s of 50 MHz cycles still fits in 32 bits
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			comm_age <= '0;
		end else if (!comm_req || comm_arm) begin
			comm_age <= '0;
		end else begin
			comm_age <= comm_age + 32'h0000_0001;
		end
	end

	sequence s_comm_arm;
		comm_arm;
	endsequence
	sequence s_comm_held;
		comm_req ##1 close_inhibit_o;
	endsequence
	sequence s_mains_back;
		!mains_bad ##1 !mains_bad;
	endsequence
	sequence s_fault_gone;
		!breaker_fault_i ##1 !breaker_fault_i;
	endsequence

	a_comm_arm: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		s_comm_arm |=> s_comm_held) else $error("comm request not raised");
	a_comm_expire: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		comm_age <= 32'(inhibit_pkg::COMM_HOLD_S * TICK_CYCLES + 2)) else $error("comm kept");
	a_comm_life: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(comm_req && !cmd_ok && comm_age < 32'((inhibit_pkg::COMM_HOLD_S - 1) * TICK_CYCLES))
		|=> comm_req) else $error("comm dropped early");
	// release paths: the timed sources must let go once the cause is gone
	a_mains_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		s_mains_back |=> !status_o.start_src[3]) else $error("mains start kept");
	a_fault_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		s_fault_gone |=> !status_o.start_src[4] && !status_o.close_src[3]) else $error("fault kept");
	a_mc_all: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		((|mc_connected_i) && ((mc_connected_i & mc_inhibit_i) == mc_connected_i))
		|=> status_o.start_src[5]) else $error("mc consensus lost");
	a_unload_mains: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		mains_bad |=> !unload_request_o) else $error("unload on mains anomaly");
	// with unload allowed and no mains anomaly, breaker stays closed until the generator has been unloaded
	a_open_wait: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		((|close_src) && unload_allowed_i && !generator_unloaded_i && !mains_bad)
		|=> !open_generator_breaker_o) else $error("opened before unload");
	a_close_sub: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(auto_submode_i && (|close_src)) |=> close_inhibit_o) else $error("sub-mode closure");
	a_start_or: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(auto_mode_i && !auto_submode_i && (|start_src)) |=> start_inhibit_o) else $error("start or");
	a_evt_gate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!evt_en |=> (start_evt_on_o == '0) && (start_evt_off_o == '0) &&
		(close_evt_on_o == '0) && !close_evt_all_off_o) else $error("event not gated");
	a_sched_day: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(!enable_days_i[weekday_i] && !after_mid) |=> status_o.start_src[1])
		else $error("disabled day allowed");
	a_din_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(!auto_mode_i && din_start_raw) |=> din_start) else $error("on-delay outside auto");
	// forced off-delay counts whole ticks, so the first one may be partial
	a_off_forced: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(gen_running_i && din_start && !din_start_raw &&
		din_cnt < DELAY_W'(inhibit_pkg::FORCED_OFF_DELAY_S)) |=> din_start) else $error("off early");
endmodule
`default_nettype wire

// [tb/remote_monitor_model.sv]
`timescale 1ns/1ns
`default_nettype none
module remote_monitor_model (
	input wire logic sys_clk_i,
	output inhibit_pkg::remote_cmd_t remote_cmd_o
);
	initial begin
		remote_cmd_o = '{valid: 1'b0, code: 8'h00};
	end
	// one-cycle command pulse, launched off the sampling edge
	task automatic send(input logic [7:0] code);
		@(negedge sys_clk_i);
		remote_cmd_o <= '{valid: 1'b1, code: code};
		@(negedge sys_clk_i);
		// stale code is inverted so nothing can latch it by accident
		remote_cmd_o <= '{valid: 1'b0, code: ~code};
	endtask
endmodule
`default_nettype wire

// [tb/genset_start_and_breaker_inhibit_bench.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module genset_start_and_breaker_inhibit_bench;
	localparam int TICK = 10;
	logic sys_clk, reset, auto_mode, submode, gen_running, clk_ok, load_stop, ptm_app, amf_app;
	logic mains_ok, brk_fault, mc_open, sync_on, brk_closed, unload_ok, unloaded;
	logic [3:0] din, start_fn, supply_fn, mc_conn, mc_inh;
	logic [15:0] on_dly, off_dly, max_fail;
	logic [6:0] en_days;
	logic [2:0] wday;
	logic [16:0] t_start, t_stop, t_now;
	logic [7:0] evt_mask;
	logic start_inh, close_inh, unload_req, open_gb, clk_bad, all_off_seen;
	logic [5:0] s_on, s_off, c_on, c_seen, s_seen_on, s_seen_off;
	logic any_off;
	inhibit_pkg::inhibit_status_t st;
	inhibit_pkg::remote_cmd_t cmd;
	int bad_count, n_checks;
	remote_monitor_model P (.sys_clk_i(sys_clk), .remote_cmd_o(cmd));
	genset_start_and_breaker_inhibit #(.TICK_CYCLES(TICK)) DUT (.sys_clk_i(sys_clk),
		.reset_i(reset), .din_i(din), .start_block_input_function_i(start_fn),
		.supply_block_input_function_i(supply_fn), .on_delay_s_i(on_dly), .off_delay_s_i(off_dly),
		.max_mains_fail_s_i(max_fail), .auto_mode_i(auto_mode), .auto_submode_i(submode),
		.gen_running_i(gen_running), .enable_days_i(en_days), .weekday_i(wday),
		.start_time_s_i(t_start), .stop_time_s_i(t_stop), .now_s_i(t_now),
		.clock_reliable_i(clk_ok), .load_mgmt_stop_i(load_stop), .parallel_to_mains_app_i(ptm_app),
		.automatic_mains_failure_app_i(amf_app), .mains_suitable_i(mains_ok),
		.breaker_fault_i(brk_fault), .mc_connected_i(mc_conn), .mc_inhibit_i(mc_inh),
		.mc_open_request_i(mc_open), .sync_in_progress_i(sync_on),
		.generator_breaker_closed_i(brk_closed), .unload_allowed_i(unload_ok),
		.generator_unloaded_i(unloaded), .remote_cmd_i(cmd), .event_mask_i(evt_mask),
		.start_inhibit_o(start_inh), .close_inhibit_o(close_inh), .unload_request_o(unload_req),
		.open_generator_breaker_o(open_gb), .clock_invalid_anomaly_o(clk_bad), .status_o(st),
		.start_evt_on_o(s_on), .start_evt_off_o(s_off), .close_evt_on_o(c_on),
		.close_evt_all_off_o(all_off_seen));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// sticky record of closure activation pulses
	always @(posedge sys_clk) c_seen <= reset ? 6'h00 : (c_seen | c_on);
	always @(posedge sys_clk) s_seen_on <= reset ? 6'h00 : (s_seen_on | s_on);
	always @(posedge sys_clk) s_seen_off <= reset ? 6'h00 : (s_seen_off | s_off);
	always @(posedge sys_clk) any_off <= reset ? 1'b0 : (any_off | all_off_seen);
	function automatic logic sched_block(input logic [6:0] en, input logic [2:0] wd,
		input logic [16:0] s0, s1, nw);
		logic [2:0] pd;
		logic ok;
		pd = (wd == 3'd0) ? 3'd6 : wd - 3'd1;
		if (s0 == s1) ok = en[wd];
		else if (s1 > s0) ok = en[wd] && nw >= s0 && nw < s1;
		else ok = (en[wd] && nw >= s0) || (en[pd] && nw < s1);
		return !ok;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic end_sim();
		if (bad_count == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#1_000_000;
		bad_count++;
		end_sim();
	end
	initial begin
		reset = 1; auto_mode = 1; submode = 0; gen_running = 0; clk_ok = 1; load_stop = 0;
		ptm_app = 0; amf_app = 0; mains_ok = 1; brk_fault = 0; mc_open = 0; sync_on = 0;
		brk_closed = 0; unload_ok = 1; unloaded = 1; din = 0; start_fn = 0; supply_fn = 0;
		mc_conn = 0; mc_inh = 0; on_dly = 0; off_dly = 0; max_fail = 16'h0002; en_days = 7'h7f;
		wday = 0; t_start = 0; t_stop = 0; t_now = 17'h0_1000; evt_mask = 8'h40;
		bad_count = 0; n_checks = 0;
		void'($urandom(32'hb43287f2));
		cyc(20);
		reset = 0;
		cyc(3);
		P.send(inhibit_pkg::CMD_ON_A);
		cyc(3);
		`CHK(st.close_src[2], 1'b1)
		`CHK(c_seen[2], 1'b1)
		P.send(inhibit_pkg::CMD_OFF);
		cyc(3);
		`CHK(st.close_src[2], 1'b0)
		P.send(inhibit_pkg::CMD_ON_B);
		cyc(25 * TICK);
		`CHK(close_inh, 1'b1)
		cyc(10 * TICK);
		`CHK(st.close_src[2], 1'b0)
		amf_app = 1; mains_ok = 0;
		P.send(inhibit_pkg::CMD_ON_A);
		cyc(3);
		`CHK(st.close_src[2], 1'b0)
		amf_app = 0; ptm_app = 1;
		cyc(5);
		`CHK({open_gb, st.close_src[1], st.start_src[3]}, 3'b110)
		cyc(4 * TICK);
		`CHK({st.start_src[3], start_inh, st.close_src[1]}, 3'b111)
		mains_ok = 1; ptm_app = 0; brk_fault = 1; brk_closed = 1; unloaded = 0;
		cyc(5);
		`CHK({st.start_src[3], st.close_src[1], st.close_src[3]}, 3'b001)
		`CHK({unload_req, open_gb}, 2'b10)
		unloaded = 1;
		cyc(4 * TICK);
		`CHK(st.start_src[4], 1'b1)
		`CHK(open_gb, 1'b1)
		brk_fault = 0; brk_closed = 0;
		cyc(5);
		`CHK({st.start_src[4], st.close_src[3]}, 2'b00)
		// forced zero on-delay outside automatic, forced 2 s off-delay while running
		auto_mode = 0; on_dly = 16'h0005; gen_running = 1; start_fn = 4'h1; din = 4'h1;
		cyc(6);
		`CHK({st.start_src[0], start_inh}, 2'b10)
		din = 0;
		cyc(6);
		`CHK(st.start_src[0], 1'b1)
		cyc(4 * TICK);
		`CHK(st.start_src[0], 1'b0)
		`CHK(s_seen_on, 6'h19)
		`CHK(s_seen_off, 6'h19)
		`CHK(c_seen, 6'h0e)
		`CHK(any_off, 1'b1)
		on_dly = 0; gen_running = 0; clk_ok = 0;
		cyc(1);
		`CHK(clk_bad, 1'b1)
		for (int i = 0; i < 40; i++) begin
			{din, start_fn, supply_fn, mc_conn, mc_inh} = 20'($urandom);
			{load_stop, mc_open, sync_on, brk_closed, auto_mode, submode} = 6'($urandom);
			{en_days, clk_ok} = 8'($urandom);
			evt_mask = 8'($urandom);
			wday = 3'($urandom % 7);
			t_start = 17'($urandom % 86400);
			t_stop = (i % 8 == 0) ? t_start : 17'($urandom % 86400);
			t_now = 17'($urandom % 86400);
			cyc(8);
			`CHK(clk_bad, !clk_ok)
			`CHK(st.start_src[0], |(din & start_fn))
			`CHK(st.start_src[1], sched_block(en_days, wday, t_start, t_stop, t_now))
			`CHK(st.start_src[2], load_stop)
			`CHK(st.start_src[5], mc_conn != 0 && (mc_inh & mc_conn) == mc_conn)
			`CHK(st.close_src[0], |(din & supply_fn))
			`CHK(st.close_src[4], sync_on && !brk_closed)
			`CHK(st.close_src[5], mc_open)
			`CHK(start_inh, auto_mode && !submode && |st.start_src)
			`CHK(close_inh, |st.close_src)
		end
		end_sim();
	end
endmodule
`default_nettype wire
